// ==== common/irq_prio_pkg.sv ====
/*
 * Shared constants for the two-level interrupt priority resolver:
 * register offsets, field positions, reset values and the source count.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package irq_prio_pkg;

    // Number of peripheral sources, one vector each
    localparam int unsigned NUM_SRC    = 16;
    localparam int unsigned VEC_W      = 4;

    // Register byte offsets
    localparam logic [11:0] main_interrupt_control_off = 12'h000;
    localparam logic [11:0] flag_off                   = 12'h004;
    localparam logic [11:0] enable_off                 = 12'h008;
    localparam logic [11:0] source_priority_select_off = 12'h00c;
    localparam logic [11:0] service_state_off          = 12'h010;
    localparam logic [11:0] event_status_off           = 12'h014;
    localparam logic [11:0] event_mask_off             = 12'h018;

    // Fields of main_interrupt_control
    localparam int unsigned GIE_BIT         = 0;  // Global enable, both levels
    localparam int unsigned LOW_EN_BIT      = 1;  // low_level_global_enable
    localparam int unsigned LEVELS_EN_BIT   = 2;  // priority_levels_enable
    localparam int unsigned VECTOR_MODE_BIT = 3;  // vectored_mode_enable

    // Event status bit positions
    localparam int unsigned EV_HIGH    = 0;  // High-level service started
    localparam int unsigned EV_LOW     = 1;  // Low-level service started
    localparam int unsigned EV_RET     = 2;  // Return taken
    localparam int unsigned EV_W       = 3;

    // Reset values
    localparam logic [3:0]         CTRL_RST = 4'h0;
    localparam logic [NUM_SRC-1:0] SRC_RST  = '0;

endpackage : irq_prio_pkg

// ==== rtl/irq_prio_resolver.sv ====
/*
 * Two-level interrupt priority resolver with APB register access.
 * Holds the source flags, enables and level selects, the control word,
 * the service nesting state, the vector offer to the core and a small
 * sticky event status with its mask and one level interrupt output.
 * Assumes request pulses from peripherals in the pclk domain, and a core
 * that fetches a vector on vector_ack and signals return on return_pulse.
 * Assumes the core pulses return_pulse once per routine, in nesting order,
 * and never takes a vector while irq_vector_valid is low.
 */
`timescale 1ns/1ps
module irq_prio_resolver
    import irq_prio_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [NUM_SRC-1:0] src_event,
    output logic                    irq_req,
    output logic                    irq_high,
    output logic      [VEC_W-1:0]   irq_vector,
    output logic                    irq_vector_valid,
    input  wire logic               vector_ack,
    input  wire logic               return_pulse,
    output logic                    irq
);

    // Nesting follows the context states: main, low, high, and high over a
    // running low. Only one vector is offered at a time; the core takes it
    // with vector_ack while irq_vector_valid stands. A return pops one
    // level. Without levels every source is high, so nothing nests and
    // only the main and high contexts are ever used.

    // Service nesting state
    typedef enum logic [1:0] {
        st_main,
        st_low,
        st_high,
        st_high_over_low
    } svc_state_t;

    // Registers written by software
    logic [3:0]         ctrl_q;       // main_interrupt_control
    logic [NUM_SRC-1:0] flag_q;       // Per-source flags
    logic [NUM_SRC-1:0] en_q;         // Per-source enables
    logic [NUM_SRC-1:0] prio_q;       // source_priority_select
    logic [EV_W-1:0]    ev_q;         // Sticky event status
    logic [EV_W-1:0]    ev_mask_q;    // Event mask
    // Service tracking and the offer to the core
    svc_state_t         state_q;      // Nesting state
    svc_state_t         state_d;
    logic [VEC_W-1:0]   vec_q;        // Registered vector
    logic               vec_hi_q;     // Registered level of vector
    logic               vec_valid_q;  // Vector valid
    // Bus side
    logic [31:0]        prdata_q;     // Read data

    // Lowest set bit index; scans from the top so the lowest set bit is
    // written last. An empty vector gives 0, so callers gate with a valid.
    function automatic logic [VEC_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [VEC_W-1:0] idx;
        idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = VEC_W'(i);
            end
        end
        return idx;
    endfunction : first_set

    // Zero-extend a per-source word to the bus width
    function automatic logic [31:0] pad_src(input logic [NUM_SRC-1:0] v);
        return {{(32-NUM_SRC){1'b0}}, v};
    endfunction : pad_src

    // Control fields
    wire gie         = ctrl_q[GIE_BIT];          // Global enable, both levels
    wire low_en      = ctrl_q[LOW_EN_BIT];       // low_level_global_enable
    wire levels_en   = ctrl_q[LEVELS_EN_BIT];    // priority_levels_enable
    wire vector_mode = ctrl_q[VECTOR_MODE_BIT];  // vectored_mode_enable

    // Bus decode
    // Access phase strobes; pready is always high, so writes land here
    wire acc        = psel & penable;
    wire wr         = acc & pwrite;
    // Word offset hits; any other address is refused with pslverr
    wire hit_ctrl   = (paddr == main_interrupt_control_off);
    wire hit_flag   = (paddr == flag_off);
    wire hit_en     = (paddr == enable_off);
    wire hit_prio   = (paddr == source_priority_select_off);
    wire hit_state  = (paddr == service_state_off);
    wire hit_ev     = (paddr == event_status_off);
    wire hit_evm    = (paddr == event_mask_off);
    wire hit_any    = hit_ctrl | hit_flag | hit_en | hit_prio | hit_state | hit_ev | hit_evm;

    // Pending enabled requests split by level; without levels all count as high
    // A cleared low enable only hides waiting lows; a running low is kept by state
    wire [NUM_SRC-1:0] pend     = flag_q & en_q;
    wire [NUM_SRC-1:0] pend_hi  = levels_en ? (pend & prio_q) : pend;
    wire [NUM_SRC-1:0] pend_lo  = levels_en ? (pend & ~prio_q) : '0;
    wire               any_hi   = gie & (|pend_hi);
    wire               any_lo   = gie & low_en & (|pend_lo);

    // Eligibility depends on nesting: equal level never preempts
    // A high may enter from main or over a running low, never over a high
    // A low may enter only from main, and only when no high wants in
    wire in_high    = (state_q == st_high) || (state_q == st_high_over_low);
    wire take_hi    = any_hi & ~in_high;
    wire take_lo    = any_lo & (state_q == st_main) & ~take_hi;
    wire take_any   = take_hi | take_lo;

    // Vectored mode resolves by lowest vector, level first
    wire [VEC_W-1:0] sel_vec = take_hi ? first_set(pend_hi) : first_set(pend_lo);

    // Next nesting state
    // A taken high over a running low pushes one level; a return pops one
    // Acks that meet no standing offer are ignored
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_main: begin
                // Single level uses st_high only
                // The level comes from the offer that the core took
                if (vector_ack && vec_valid_q) begin
                    state_d = vec_hi_q ? st_high : st_low;
                end
            end
            st_low: begin
                // Only a high vector can be taken here
                if (vector_ack && vec_valid_q && vec_hi_q) begin
                    state_d = st_high_over_low;
                end else if (return_pulse) begin
                    state_d = st_main;
                end
            end
            st_high: begin
                // Back to main; pending highs then win over waiting lows
                if (return_pulse) begin
                    state_d = st_main;
                end
            end
            st_high_over_low: begin
                // Resume low even if its enable cleared
                // The low context comes back, not a fresh offer
                if (return_pulse) begin
                    state_d = st_low;
                end
            end
            default: begin
                // Unused code, recover to main
                state_d = st_main;
            end
        endcase
    end

    // Nesting state register
    // Reset returns to the main context
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= st_main;
        end else begin
            state_q <= state_d;
        end
    end

    // Offered vector; dropped if request vanishes or is taken
    // The offer is re-ranked every cycle until the core takes it, so a
    // high arriving late replaces a standing low offer before the ack.
    // On the ack edge the offer drops; the next offer waits one cycle so
    // that it is ranked against the new nesting state and, in vectored mode, the cleared flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Nothing offered after reset
            vec_q       <= '0;
            vec_hi_q    <= 1'b0;
            vec_valid_q <= 1'b0;
        end else if (vector_ack && vec_valid_q) begin
            // Taken: withdraw, keep vector and level for the state update
            vec_valid_q <= 1'b0;
        end else begin
            // Re-rank; polled mode leaves the search to software
            vec_valid_q <= take_any;
            vec_q       <= vector_mode ? sel_vec : '0;
            vec_hi_q    <= take_hi;
        end
    end

    // Flag set by event wins over clear; acked vector clears its flag in vectored mode
    // In polled mode the routine clears its own flag
    wire [NUM_SRC-1:0] ack_clr = (vector_ack && vec_valid_q && vector_mode) ? (NUM_SRC'(1) << vec_q) : '0;
    // Software write loads the word: zeros clear, ones set
    wire [NUM_SRC-1:0] sw_clr  = (wr && hit_flag) ? ~pwdata[NUM_SRC-1:0] : '0;
    wire [NUM_SRC-1:0] sw_set  = (wr && hit_flag) ? pwdata[NUM_SRC-1:0] : '0;

    // Source flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= SRC_RST;
        end else begin
            // Event set has the last word
            flag_q <= ((flag_q & ~sw_clr & ~ack_clr) | sw_set) | src_event;
        end
    end

    // Control and configuration registers
    // Unmapped and read-only offsets are ignored on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= CTRL_RST;
            en_q      <= SRC_RST;
            prio_q    <= SRC_RST;
            ev_mask_q <= '0;
        end else if (wr) begin
            // One register per write; the offer re-ranks next cycle
            if (hit_ctrl) begin
                ctrl_q <= pwdata[3:0];
            end else if (hit_en) begin
                en_q <= pwdata[NUM_SRC-1:0];
            end else if (hit_prio) begin
                prio_q <= pwdata[NUM_SRC-1:0];
            end else if (hit_evm) begin
                ev_mask_q <= pwdata[EV_W-1:0];
            end
        end
    end

    // Service events; set wins over write-one-to-clear
    // Bit order, top down: return, low taken, high taken
    wire           acked  = vector_ack & vec_valid_q;
    wire [EV_W-1:0] ev_set = {return_pulse, acked & ~vec_hi_q, acked & vec_hi_q};
    wire [EV_W-1:0] ev_clr = (wr && hit_ev) ? pwdata[EV_W-1:0] : '0;

    // Sticky event status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_q <= '0;
        end else begin
            // Write-one-to-clear; an event in the same cycle wins
            ev_q <= (ev_q & ~ev_clr) | ev_set;
        end
    end

    // Read mux: one register per word offset, zero elsewhere
    logic [31:0] rd_mux;                 // Value of the addressed register
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux = {28'h000_0000, ctrl_q};
        end else if (hit_flag) begin
            rd_mux = pad_src(flag_q);
        end else if (hit_en) begin
            rd_mux = pad_src(en_q);
        end else if (hit_prio) begin
            rd_mux = pad_src(prio_q);
        end else if (hit_state) begin
            rd_mux = {30'h0, state_q};
        end else if (hit_ev) begin
            rd_mux = {29'h0, ev_q};
        end else if (hit_evm) begin
            rd_mux = {29'h0, ev_mask_q};
        end
    end

    // Read data register, loaded in setup cycle
    // Held through the access phase and until the next read setup
    // Writes leave it alone, so a read result stays visible
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    // Outputs
    // Zero wait states: every access ends after one access cycle
    // The offer and its level come straight from flip-flops
    assign prdata           = prdata_q;
    assign pready           = 1'b1;
    assign pslverr          = acc & ~hit_any;
    assign irq_req          = vec_valid_q;
    assign irq_high         = vec_hi_q;
    assign irq_vector       = vec_q;
    assign irq_vector_valid = vec_valid_q;
    assign irq              = |(ev_q & ev_mask_q);

endmodule : irq_prio_resolver

// ==== verif/irq_prio_asserts.sv ====
/* Port checker for the priority resolver: nesting, offers, APB errors.
   Assumes it is bound to irq_prio_resolver and sees only its ports. */
`timescale 1ns/1ps
module irq_prio_asserts
    import irq_prio_pkg::*;
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pslverr,
    input wire logic               irq_req,
    input wire logic               irq_high,
    input wire logic [VEC_W-1:0]   irq_vector,
    input wire logic               irq_vector_valid,
    input wire logic               vector_ack,
    input wire logic               return_pulse
);
    logic       hi_act_q;                                  // High routine running
    logic       lo_act_q;                                  // Low routine running
    logic [3:0] ctl_q;                                     // Shadow of control register
    logic [3:0] ctl_old_q;                                 // Shadow one cycle older
    wire        take = vector_ack && irq_vector_valid;     // Core takes the offer
    wire        bad  = !(paddr inside {main_interrupt_control_off, flag_off, enable_off,
                          source_priority_select_off, service_state_off, event_status_off,
                          event_mask_off});                // Unmapped address
    wire        levels_off = !ctl_q[LEVELS_EN_BIT] && !ctl_old_q[LEVELS_EN_BIT];     // Levels off for two cycles
    wire        polled     = !ctl_q[VECTOR_MODE_BIT] && !ctl_old_q[VECTOR_MODE_BIT]; // Polled for two cycles
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Track nesting and the control word as the core and software see them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_act_q  <= 1'b0;
            lo_act_q  <= 1'b0;
            ctl_q     <= CTRL_RST;
            ctl_old_q <= CTRL_RST;
        end else begin
            hi_act_q  <= (take && irq_high) || (hi_act_q && !return_pulse);
            lo_act_q  <= (take && !irq_high) || (lo_act_q && !(return_pulse && !hi_act_q));
            ctl_old_q <= ctl_q;
            if (psel && penable && pwrite && paddr == main_interrupt_control_off) begin
                ctl_q <= pwdata[3:0];
            end
        end
    end
    no_high_preempt_a: assert property (hi_act_q |-> !irq_vector_valid)
        else $error("offer made during high service");
    low_preempt_only_a: assert property (lo_act_q && irq_vector_valid |-> irq_high)
        else $error("low routine offered a low vector");
    req_tracks_valid_a: assert property (irq_req == irq_vector_valid)
        else $error("request and valid disagree");
    offer_withdrawn_a: assert property (take |=> !irq_req && !irq_vector_valid)
        else $error("offer stood after it was taken");
    single_level_a: assert property (levels_off && irq_vector_valid |-> irq_high)
        else $error("low level offered with levels off");
    polled_vector_a: assert property (polled && irq_vector_valid |-> irq_vector == '0)
        else $error("vector given with vectored mode off");
    err_unmapped_a: assert property (psel && penable && bad |-> pslverr)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (psel && penable && !bad |-> !pslverr)
        else $error("mapped access refused");
    read_unmapped_a: assert property (psel && !penable && !pwrite && bad |=> prdata == '0)
        else $error("unmapped read not zero");
    cover property (take && irq_high);
    cover property (take && !irq_high);
    cover property (return_pulse && hi_act_q && lo_act_q);
    cover property (take && irq_high && lo_act_q);
endmodule : irq_prio_asserts
bind irq_prio_resolver irq_prio_asserts irq_prio_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pslverr, .irq_req, .irq_high, .irq_vector, .irq_vector_valid, .vector_ack, .return_pulse);

// ==== verif/core_model.sv ====
/* Processor core model: takes offered vectors after a set delay, returns on request.
   Assumes pclk domain and a bench that raises ret_req for one cycle. */
`timescale 1ns/1ps
module core_model
    import irq_prio_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             irq_vector_valid,
    input  wire logic             irq_high,
    input  wire logic [VEC_W-1:0] irq_vector,
    input  wire logic [3:0]       ack_delay,
    input  wire logic             ret_req,
    output logic                  vector_ack,
    output logic                  return_pulse,
    output logic      [VEC_W-1:0] got_vec,
    output logic                  got_high,
    output logic      [7:0]       got_cnt
);
    logic [3:0] wait_q;                                    // Cycles the offer has stood
    // Acknowledge after ack_delay cycles; log at the edge where ack meets the offer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {vector_ack, return_pulse, got_vec, got_high, got_cnt, wait_q} <= '0;
        end else begin
            return_pulse <= ret_req;
            vector_ack   <= 1'b0;
            // The offer may be re-ranked before ack lands, so log what stands then
            if (vector_ack && irq_vector_valid) begin
                got_vec  <= irq_vector;
                got_high <= irq_high;
                got_cnt  <= got_cnt + 8'h01;
            end
            if (irq_vector_valid && !vector_ack && wait_q == ack_delay) begin
                vector_ack <= 1'b1;
                wait_q     <= '0;
            end else begin
                wait_q <= (irq_vector_valid && !vector_ack) ? wait_q + 4'h1 : 4'h0;
            end
        end
    end
endmodule : core_model

// ==== verif/test_two_level_interrupt_priority_resolver.sv ====
/* Self-checking bench: priority order, preemption, deferral, single level, events.
   Assumes the core model answers the core side and the bench is the APB master. */
`timescale 1ns/1ps
module test_two_level_interrupt_priority_resolver
    import irq_prio_pkg::*;
();
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ret_req = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [NUM_SRC-1:0] src_event = '0;
    logic pready, pslverr, irq_req, irq_high, irq_vector_valid, vector_ack, return_pulse, irq, e, got_high;
    logic [VEC_W-1:0] irq_vector, got_vec;
    logic [3:0] ack_delay = '0;
    logic [7:0] got_cnt, seen_n = '0;
    int err_total = 0, total_checks = 0;
    always #10 pclk = ~pclk;
    irq_prio_resolver irq_prio_resolver_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .src_event, .irq_req, .irq_high, .irq_vector, .irq_vector_valid,
        .vector_ack, .return_pulse, .irq);
    core_model core_model_inst (.pclk, .presetn, .irq_vector_valid, .irq_high, .irq_vector, .ack_delay,
        .ret_req, .vector_ack, .return_pulse, .got_vec, .got_high, .got_cnt);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One APB transfer; read data and error land in r and e
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic fire(input logic [NUM_SRC-1:0] m);
        @(posedge pclk);
        src_event <= m;
        @(posedge pclk);
        src_event <= '0;
    endtask : fire
    task automatic ret();
        @(posedge pclk);
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : ret
    // Wait for the core to take a vector, then compare it
    task automatic take(input logic [3:0] v, input logic h);
        int n;
        for (n = 0; n < 100 && got_cnt === seen_n; n++) @(posedge pclk);
        chk("taken", {24'h0, got_cnt}, {24'h0, seen_n + 8'h01});
        seen_n = got_cnt;
        chk("vector", {28'h0, got_vec}, {28'h0, v});
        chk("level", {31'h0, got_high}, {31'h0, h});
    endtask : take
    task automatic state(input logic [31:0] x);
        apb(1'b0, service_state_off, '0);
        chk("state", r, x);
    endtask : state
    task automatic s_regs();
        apb(1'b0, main_interrupt_control_off, '0);
        chk("ctrl", r, {28'h0, CTRL_RST});
        apb(1'b1, source_priority_select_off, 32'h0000_1200);
        apb(1'b0, source_priority_select_off, '0);
        chk("prio", r, 32'h0000_1200);
        apb(1'b0, 12'h020, '0);
        chk("slverr", {31'h0, e}, 32'h1);
        chk("bad read", r, '0);
    endtask : s_regs
    task automatic s_flags();
        fire(16'h0020);
        apb(1'b0, flag_off, '0);
        chk("flags", r, 32'h0000_0020);
        apb(1'b1, enable_off, 32'h0000_0020);
        apb(1'b1, main_interrupt_control_off, 32'h1);
        take(4'h0, 1'b1);
        apb(1'b1, flag_off, '0);
        ret();
    endtask : s_flags
    task automatic s_prio();
        apb(1'b1, enable_off, 32'h0000_ffff);
        apb(1'b1, main_interrupt_control_off, 32'hf);
        fire(16'h1204);
        take(4'h9, 1'b1);
        state(32'h2);
        ret();
        take(4'hc, 1'b1);
        ret();
        take(4'h2, 1'b0);
        state(32'h1);
        ret();
    endtask : s_prio
    task automatic s_preempt();
        ack_delay <= 4'h3;
        fire(16'h0008);
        take(4'h3, 1'b0);
        apb(1'b1, main_interrupt_control_off, 32'hd);
        fire(16'h0200);
        take(4'h9, 1'b1);
        state(32'h3);
        ret();
        state(32'h1);
        ret();
        state(32'h0);
        ack_delay <= 4'h0;
    endtask : s_preempt
    task automatic s_drop();
        apb(1'b1, main_interrupt_control_off, 32'hf);
        fire(16'h0210);
        take(4'h9, 1'b1);
        apb(1'b1, main_interrupt_control_off, 32'hd);
        ret();
        repeat (20) @(posedge pclk);
        chk("dropped", {24'h0, got_cnt}, {24'h0, seen_n});
        apb(1'b0, flag_off, '0);
        chk("left flag", r, 32'h0000_0010);
        apb(1'b1, flag_off, '0);
    endtask : s_drop
    task automatic s_single();
        apb(1'b1, main_interrupt_control_off, 32'h9);
        fire(16'h1020);
        take(4'h5, 1'b1);
        fire(16'h0001);
        ret();
        take(4'h0, 1'b1);
        ret();
        take(4'hc, 1'b1);
        ret();
    endtask : s_single
    task automatic s_irq();
        chk("irq masked", {31'h0, irq}, '0);
        apb(1'b1, event_mask_off, 32'h7);
        repeat (2) @(posedge pclk);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b0, event_status_off, '0);
        chk("events", r, 32'h0000_0007);
        apb(1'b0, event_mask_off, '0);
        chk("event mask", r, 32'h0000_0007);
        apb(1'b1, event_status_off, 32'h7);
        repeat (2) @(posedge pclk);
        chk("irq off", {31'h0, irq}, '0);
        apb(1'b0, event_status_off, '0);
        chk("events cleared", r, '0);
    endtask : s_irq
    task automatic conclude();
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        #200us;
        err_total++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_flags();
        s_prio();
        s_preempt();
        s_drop();
        s_single();
        s_irq();
        conclude();
    end
endmodule : test_two_level_interrupt_priority_resolver
